// [shared/dml_pkg.sv]
`default_nettype none
package dml_pkg;
	// =====================================================
	// Host access pins
	typedef struct packed {
		logic       reg_sel;
		logic       read_write;
		logic       strobe;
	} dml_ctl_type;
	// Display address pair
	typedef struct packed {
		logic [2:0] column_addr;
		logic [3:0] row_addr;
	} dml_addr_type;
endpackage
`default_nettype wire

// [shared/dml_regs.svh]
`ifndef DML_REGS_SVH
`define DML_REGS_SVH
// =====================================================
// Index codes
`define DML_IDX_STBY_DUTY   3'h0
`define DML_IDX_POWER       3'h1
`define DML_IDX_ADDRESS     3'h2
`define DML_IDX_FRAME       3'h3
`define DML_IDX_DATA        3'h4
// =====================================================
// Field positions
`define DML_BIT_SLEEP       5
`define DML_BIT_DUTY        1
`define DML_BIT_DISPLAY     6
`define DML_BIT_SUPPLY      5
`define DML_BIT_DIVRES      4
`define DML_BIT_WOADV       3
`define DML_BIT_AXIS        1
`define DML_COL_HI          7
`define DML_COL_LO          5
`define DML_ROW_HI          3
`define DML_ROW_LO          0
// =====================================================
// Reset values and limits
`define DML_RESET_BYTE      8'h00
`define DML_COL_MAX         3'h4
`define DML_ROW_MAX_16      4'hf
`define DML_ROW_MAX_8       4'h7
`define DML_DUTY_N16        8'h10
`define DML_DUTY_N8         8'h08
`endif

// [sim/dml_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dml_regs.svh"
module dml_core_tb_top;
	logic       i_clock = 1'b0;
	logic       i_rst = 1'b1;
	logic       i_sub_tick = 1'b0;
	logic       reg_sel;
	logic       rw;
	logic       strobe;
	logic [7:0] hdat;
	logic [7:0] dout;
	logic       oe;
	logic       slp, e8, don, sup, dvr, fb, rtk, ftk;
	logic [2:0] fsel;
	logic [7:0] bus;
	logic [7:0] q;
	int         bad_count = 0;
	int         tests_run = 0;
	// Shared data wire
	assign bus = oe ? dout : hdat;
	always #5 i_clock = ~i_clock;
	// Subclock enable every other cycle
	always @(posedge i_clock) i_sub_tick <= ~i_sub_tick;
	dml_host_model host (.i_clock(i_clock), .i_data_lines(bus),
		.o_register_select(reg_sel), .o_read_write(rw), .o_access_strobe(strobe),
		.o_data_lines(hdat));
	dml_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_register_select(reg_sel),
		.i_read_write(rw), .i_access_strobe(strobe), .i_data_lines(bus),
		.i_sub_tick(i_sub_tick), .o_data_lines(dout), .o_data_lines_oe(oe),
		.o_module_sleep(slp), .o_eighth_duty(e8), .o_display_on(don),
		.o_internal_supply_on(sup), .o_divider_resistors_on(dvr),
		.o_first_bias_output_on(fb), .o_frame_div_sel(fsel),
		.o_row_tick(rtk), .o_frame_tick(ftk));
	// ==========================================
	// Checking and closing
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
	begin
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task automatic end_sim;
	begin
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task automatic rdchk(logic [7:0] exp);
	begin
		host.rd(q);
		chk("read byte", q, exp);
		chk("read oe", oe, 1'b1);
	end
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
	begin
		@(posedge i_clock) i_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		chk("reset ctl", {slp, e8, don, sup, dvr, fb, oe, fsel}, 0);
	end
	endtask
	task automatic t_power;
	begin
		host.wr(`DML_IDX_POWER, 8'h70);
		chk("power on", {don, sup, dvr, fb}, 4'hf);
		host.wr(`DML_IDX_STBY_DUTY, 8'h20);
		chk("sleep", {slp, don, sup, dvr, fb}, 5'h10);
		host.wr(`DML_IDX_STBY_DUTY, 8'h02);
		chk("wake duty", {slp, e8, don}, 3'h2);
	end
	endtask
	task automatic t_memory;
	begin
		host.wr(`DML_IDX_POWER, 8'h00);
		host.wr(`DML_IDX_ADDRESS, 8'h00);
		for (int i = 0; i < 9; i++) host.wr(`DML_IDX_DATA, 8'(8'h10 + i));
		host.wr(`DML_IDX_ADDRESS, 8'h00);
		host.sel(`DML_IDX_DATA);
		// ninth byte lands in column one
		for (int i = 0; i < 9; i++) rdchk(8'(8'h10 + i));
		host.wr(`DML_IDX_STBY_DUTY, 8'h00);
		host.wr(`DML_IDX_ADDRESS, 8'h4e);
		host.wr(`DML_IDX_DATA, 8'haa);
		host.wr(`DML_IDX_DATA, 8'hbb);
		host.wr(`DML_IDX_DATA, 8'hcc);
		host.wr(`DML_IDX_ADDRESS, 8'h4f);
		host.sel(`DML_IDX_DATA);
		rdchk(8'hbb);
		rdchk(8'hcc);
	end
	endtask
	task automatic t_axis;
	begin
		host.wr(`DML_IDX_POWER, 8'h02);
		host.wr(`DML_IDX_ADDRESS, 8'h83);
		host.wr(`DML_IDX_DATA, 8'h3c);
		host.wr(`DML_IDX_DATA, 8'hc3);
		host.wr(`DML_IDX_ADDRESS, 8'h83);
		host.sel(`DML_IDX_DATA);
		rdchk(8'h3c);
		rdchk(8'hc3);
		host.wr(`DML_IDX_POWER, 8'h0a);
		host.wr(`DML_IDX_ADDRESS, 8'h00);
		host.sel(`DML_IDX_DATA);
		rdchk(8'h10);
		rdchk(8'h10);
		host.wr(`DML_IDX_DATA, 8'h77);
		rdchk(8'h18);
	end
	endtask
	task automatic t_refuse;
	begin
		host.sel(`DML_IDX_STBY_DUTY);
		host.rd(q);
		chk("ctl read oe", oe, 1'b0);
		host.wr(3'h5, 8'h20);
		chk("bad index", {slp, sup, fsel}, 5'h00);
	end
	endtask
	task automatic t_frame(logic [2:0] code, logic eighth);
		int n;
		int g;
		int r;
	begin
		// both supply bits clear, display running
		host.wr(`DML_IDX_POWER, 8'h40);
		host.wr(`DML_IDX_STBY_DUTY, {6'h00, eighth, 1'b0});
		host.wr(`DML_IDX_FRAME, {5'h00, code});
		chk("div sel", fsel, code);
		for (int f = 0; f < 2; f++)
		begin
			n = 0;
			g = 0;
			while (n < 3 && g < 9000)
			begin
				@(posedge i_clock);
				if (n == 2) g++;
				if ((f ? ftk : rtk) === 1'b1) n++;
			end
			r = 2 << code;
			chk(f ? "frame gap" : "row gap", g, f ? r * (eighth ? 16 : 32) : r * 2);
		end
	end
	endtask
	// Watchdog
	initial
	begin
		repeat (40000) @(posedge i_clock);
		bad_count++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		t_reset();
		t_power();
		t_memory();
		t_axis();
		t_refuse();
		t_frame(3'h1, 1'b1);
		t_frame(3'h2, 1'b0);
		t_frame(3'h0, 1'b1);
		t_frame(3'h6, 1'b0);
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire

// [sim/dml_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dml_regs.svh"
// ==========================================
// Host port model
module dml_host_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_data_lines,
	output logic            o_register_select,
	output logic            o_read_write,
	output logic            o_access_strobe,
	output logic [7:0]      o_data_lines
);
	// Idle pins, strobe high so no fall occurs
	initial
	begin
		o_register_select = 1'b1;
		o_read_write = 1'b1;
		o_access_strobe = 1'b1;
		o_data_lines = 8'h00;
	end
	// One strobed access, read byte taken while driven
	task automatic access(input logic reg_sel, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
	begin
		@(posedge i_clock);
		o_register_select <= reg_sel;
		o_read_write <= rw;
		// Released lines show the inverse, not the old byte
		o_data_lines <= rw ? ~o_data_lines : d;
		repeat (4) @(posedge i_clock);
		o_access_strobe <= 1'b0;
		repeat (6) @(posedge i_clock);
		q = i_data_lines;
		o_access_strobe <= 1'b1;
		repeat (4) @(posedge i_clock);
	end
	endtask
	// index code with reserved bits zero
	task automatic sel(input logic [2:0] idx);
		logic [7:0] q;
	begin
		access(1'b0, 1'b0, {5'h00, idx}, q);
	end
	endtask
	// callers keep column within zero to four
	task automatic wr(input logic [2:0] idx, input logic [7:0] v);
		logic [7:0] q;
	begin
		sel(idx);
		access(1'b1, 1'b0, v, q);
	end
	endtask
	// Read of the selected register
	task automatic rd(output logic [7:0] q);
	begin
		access(1'b1, 1'b1, 8'h00, q);
	end
	endtask
endmodule
`default_nettype wire

// [src/dml_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dml_regs.svh"
module dml_core
	import dml_pkg::*;
#(
	parameter int COLS = 5,
	parameter int ROWS = 16
)(
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic         i_register_select,
	input  wire logic         i_read_write,
	input  wire logic         i_access_strobe,
	input  wire logic [7:0]   i_data_lines,
	input  wire logic         i_sub_tick,
	output logic [7:0]        o_data_lines,
	output logic              o_data_lines_oe,
	output logic              o_module_sleep,
	output logic              o_eighth_duty,
	output logic              o_display_on,
	output logic              o_internal_supply_on,
	output logic              o_divider_resistors_on,
	output logic              o_first_bias_output_on,
	output logic [2:0]        o_frame_div_sel,
	output logic              o_row_tick,
	output logic              o_frame_tick
);
	// =====================================================
	// Pin synchronisers
	dml_ctl_type  ctl_s1;
	dml_ctl_type  ctl_s2;
	dml_ctl_type  ctl_prev;
	logic [7:0]   din_s1;
	logic [7:0]   din_s2;
	// Register state
	logic [2:0]   index_field;
	logic [7:0]   standby_duty_control;
	logic [7:0]   display_power_control;
	dml_addr_type display_address;
	logic [2:0]   frame_div_sel;
	logic [7:0]   display_data_port;
	logic         drive;
	logic [2:0]   next_index_field;
	logic [7:0]   next_standby_duty_control;
	logic [7:0]   next_display_power_control;
	dml_addr_type next_display_address;
	logic [2:0]   next_frame_div_sel;
	logic [7:0]   next_display_data_port;
	logic         next_drive;
	// Display memory, no reset
	logic [7:0]   mem [COLS*ROWS];
	logic         strobe_fall;
	logic         wr_ctl;
	logic         rd_data;
	logic         wr_data;
	logic         mem_we;
	logic         advance;
	logic [6:0]   mem_idx;

	// Linear memory index from the address pair
	function automatic logic [6:0] addr_index(input dml_addr_type a);
		addr_index = 7'({a.row_addr, 3'h0}) - 7'({a.row_addr, 1'b0}) + 7'({3'h0, a.row_addr})
			- 7'({a.row_addr}) + 7'(a.row_addr) * 7'(0) + 7'(a.row_addr) * 7'(COLS)
			- 7'({a.row_addr, 3'h0}) + 7'({a.row_addr, 1'b0}) + 7'(a.column_addr);
	endfunction

	// Auto-advance of the address pair
	function automatic dml_addr_type bump(input dml_addr_type a, input logic col_first,
		input logic eighth);
		logic [3:0] rmax;
		logic       col_wrap;
		logic       row_wrap;
		begin
			rmax = eighth ? `DML_ROW_MAX_8 : `DML_ROW_MAX_16;
			col_wrap = a.column_addr >= `DML_COL_MAX;
			row_wrap = a.row_addr >= rmax;
			bump = a;
			if (col_first)
			begin
				bump.column_addr = col_wrap ? 3'h0 : a.column_addr + 3'h1;
				if (col_wrap)
					bump.row_addr = row_wrap ? 4'h0 : a.row_addr + 4'h1;
			end
			else
			begin
				bump.row_addr = row_wrap ? 4'h0 : a.row_addr + 4'h1;
				if (row_wrap)
					bump.column_addr = col_wrap ? 3'h0 : a.column_addr + 3'h1;
			end
		end
	endfunction

	// =====================================================
	// Two-flop input capture
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ctl_s1 <= '0;
			ctl_s2 <= '0;
			ctl_prev <= '0;
			din_s1 <= `DML_RESET_BYTE;
			din_s2 <= `DML_RESET_BYTE;
		end
		else
		begin
			ctl_s1 <= '{i_register_select, i_read_write, i_access_strobe};
			ctl_s2 <= ctl_s1;
			ctl_prev <= ctl_s2;
			din_s1 <= i_data_lines;
			din_s2 <= din_s1;
		end
	end

	// =====================================================
	// Access decode
	// falling edge of the strobe
	assign strobe_fall = ctl_prev.strobe & ~ctl_s2.strobe;
	assign wr_ctl = strobe_fall & ctl_s2.reg_sel & ~ctl_s2.read_write;
	assign rd_data = strobe_fall & ctl_s2.reg_sel & ctl_s2.read_write
		& (index_field == `DML_IDX_DATA);
	assign wr_data = wr_ctl & (index_field == `DML_IDX_DATA);
	assign mem_idx = addr_index(display_address);
	// advance on data writes, data reads too unless write-only advance
	assign advance = wr_data | (rd_data
		& ~display_power_control[`DML_BIT_WOADV]);
	assign mem_we = wr_data;

	// =====================================================
	// Next register values
	always_comb
	begin
		next_index_field = index_field;
		next_standby_duty_control = standby_duty_control;
		next_display_power_control = display_power_control;
		next_display_address = display_address;
		next_frame_div_sel = frame_div_sel;
		next_display_data_port = display_data_port;
		next_drive = drive;
		if (strobe_fall && !ctl_s2.reg_sel && !ctl_s2.read_write)
			next_index_field = din_s2[2:0];
		if (wr_ctl)
		begin
			case (index_field)
				`DML_IDX_STBY_DUTY: next_standby_duty_control = din_s2;
				`DML_IDX_POWER:     next_display_power_control = din_s2;
				`DML_IDX_ADDRESS:   next_display_address = dml_addr_type'({din_s2[7:5], din_s2[3:0]});
				`DML_IDX_FRAME:     next_frame_div_sel = din_s2[2:0];
				default:            next_frame_div_sel = frame_div_sel;
			endcase
		end
		// sleep clears display and power bits
		if (next_standby_duty_control[`DML_BIT_SLEEP])
		begin
			next_display_power_control[`DML_BIT_DISPLAY] = 1'b0;
			next_display_power_control[`DML_BIT_SUPPLY] = 1'b0;
			next_display_power_control[`DML_BIT_DIVRES] = 1'b0;
		end
		if (rd_data)
			next_display_data_port = mem[mem_idx];
		// drive on data read, release when write or index register chosen
		if (rd_data)
			next_drive = 1'b1;
		else if (!ctl_s2.read_write || !ctl_s2.reg_sel)
			next_drive = 1'b0;
		if (advance)
			next_display_address = bump(display_address,
				display_power_control[`DML_BIT_AXIS],
				standby_duty_control[`DML_BIT_DUTY]);
	end

	// =====================================================
	// Register update
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			index_field <= 3'h0;
			standby_duty_control <= `DML_RESET_BYTE;
			display_power_control <= `DML_RESET_BYTE;
			display_address <= '0;
			frame_div_sel <= 3'h0;
			drive <= 1'b0;
		end
		else
		begin
			index_field <= next_index_field;
			standby_duty_control <= next_standby_duty_control;
			display_power_control <= next_display_power_control;
			display_address <= next_display_address;
			frame_div_sel <= next_frame_div_sel;
			drive <= next_drive;
		end
	end

	// =====================================================
	// memory and data latch unreset
	always_ff @(posedge i_clock)
	begin
		display_data_port <= next_display_data_port;
		if (mem_we)
			mem[mem_idx] <= din_s2;
	end

	// =====================================================
	// Outputs
	assign o_data_lines = display_data_port;
	assign o_data_lines_oe = drive;
	assign o_module_sleep = standby_duty_control[`DML_BIT_SLEEP];
	assign o_eighth_duty = standby_duty_control[`DML_BIT_DUTY];
	assign o_display_on = display_power_control[`DML_BIT_DISPLAY];
	assign o_internal_supply_on = display_power_control[`DML_BIT_SUPPLY];
	assign o_first_bias_output_on = display_power_control[`DML_BIT_SUPPLY];
	assign o_divider_resistors_on = display_power_control[`DML_BIT_DIVRES];
	assign o_frame_div_sel = frame_div_sel;

	// =====================================================
	// frame timing
	dml_frame_timer #(
		.CW (16)
	) u_timer (
		.i_clock         (i_clock),
		.i_rst           (i_rst),
		.i_sub_tick      (i_sub_tick & ~o_module_sleep),
		.i_frame_div_sel (frame_div_sel),
		.i_duty_eighth   (o_eighth_duty),
		.o_row_tick      (o_row_tick),
		.o_frame_tick    (o_frame_tick)
	);

	// =====================================================
	// Checks
	// sleep clears power bits
	chk_sleep_clears_power: assert property (@(posedge i_clock) disable iff (i_rst)
		o_module_sleep |-> !o_display_on && !o_internal_supply_on && !o_divider_resistors_on)
		else $error("power bits set in standby");
	chk_reset_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		$past(i_rst) |-> index_field == 3'h0 && !o_display_on && frame_div_sel == 3'h0)
		else $error("registers not cleared by reset");
	chk_index_capture: assert property (@(posedge i_clock) disable iff (i_rst)
		strobe_fall && !ctl_s2.reg_sel && !ctl_s2.read_write |=> index_field == $past(din_s2[2:0]))
		else $error("index not captured");
	chk_read_drives: assert property (@(posedge i_clock) disable iff (i_rst)
		rd_data |=> o_data_lines_oe && o_data_lines == $past(mem[mem_idx]))
		else $error("read data not driven");
	// no advance on read in write-only advance
	chk_read_addr_hold: assert property (@(posedge i_clock) disable iff (i_rst)
		rd_data && display_power_control[`DML_BIT_WOADV] && !wr_ctl |=> $stable(display_address))
		else $error("address moved on read with write-only advance");
	chk_col_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
		advance && display_power_control[`DML_BIT_AXIS] && display_address.column_addr == 3'h4
		|=> display_address.column_addr == 3'h0)
		else $error("column did not wrap");
	chk_row_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
		advance && !display_power_control[`DML_BIT_AXIS] && o_eighth_duty
		&& display_address.row_addr == 4'h7 |=> display_address.row_addr == 4'h0)
		else $error("row did not wrap at eighth duty");
	chk_no_ctl_read: assert property (@(posedge i_clock) disable iff (i_rst)
		strobe_fall && ctl_s2.read_write && index_field != `DML_IDX_DATA && !drive
		|=> !o_data_lines_oe)
		else $error("drove lines on control read");
endmodule
`default_nettype wire

// [src/dml_frame_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dml_regs.svh"
// Frame timer: subclock divided by ratio r then by duty N
module dml_frame_timer
	import dml_pkg::*;
#(
	parameter int CW = 16
)(
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_sub_tick,
	input  wire logic [2:0] i_frame_div_sel,
	input  wire logic       i_duty_eighth,
	output logic            o_row_tick,
	output logic            o_frame_tick
);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [CW-1:0] limit;
	logic          next_frame;
	logic          next_row;

	// =====================================================
	// Terminal count r*N-1 and row strobe every r ticks
	always_comb
	begin
		limit = CW'((CW'(2) << i_frame_div_sel)
			* CW'(i_duty_eighth ? `DML_DUTY_N8 : `DML_DUTY_N16)) - CW'(1);
		next_count = count;
		next_frame = 1'b0;
		next_row = 1'b0;
		if (i_sub_tick)
		begin
			next_row = ((count + CW'(1)) & ((CW'(2) << i_frame_div_sel) - CW'(1))) == '0;
			if (count >= limit)
			begin
				next_count = '0;
				next_frame = 1'b1;
			end
			else
				next_count = count + CW'(1);
		end
	end

	// =====================================================
	// Registers
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			count <= '0;
			o_frame_tick <= 1'b0;
			o_row_tick <= 1'b0;
		end
		else
		begin
			count <= next_count;
			o_frame_tick <= next_frame;
			o_row_tick <= next_row;
		end
	end
endmodule
`default_nettype wire
